// ---- rtl/vsp_defines.svh ----
// constants of the video stream port: widths, latency, response codes
`ifndef VSP_DEFINES_SVH
`define VSP_DEFINES_SVH

// ************************************************************
// stream word layout
// ************************************************************
`define VSP_COMP_W        8
`define VSP_PIX_W         24
`define VSP_SOF_BIT       0

// ************************************************************
// pipeline latency: base plus upper and lower limit stages
// ************************************************************
`define VSP_LAT_BASE      9
`define VSP_LAT_CLIP      1
`define VSP_LAT_CLAMP     1
`define VSP_LATENCY       (`VSP_LAT_BASE + `VSP_LAT_CLIP + `VSP_LAT_CLAMP)

// ************************************************************
// stream reset hold, in cycles of the slowest clock
// ************************************************************
`define VSP_RST_MIN_CYC   32

// ************************************************************
// control port widths and answers
// ************************************************************
`define VSP_CTL_ADDR_W    32
`define VSP_CTL_DATA_W    32
`define VSP_CTL_RESP_W    2
`define VSP_RESP_SLVERR   2'h2
`define VSP_RDATA_RST     32'h00000000

`endif

// ---- rtl/vsp_pkg.sv ----
// types of the video stream port
package vsp_pkg;
    typedef logic [23:0] vsp_pix_t;
    typedef logic [1:0]  vsp_resp_t;
    typedef logic [3:0]  vsp_run_t;
endpackage

// ---- rtl/vsp_stream_port.sv ----
// video stream port: stream handshake, markers, pipeline and control port
//
// Behaviour
// - stream inputs sampled on rising clock edge; registered outputs change only after it, o_s_tready is combinational.
// - with stream enable low, all stream state and output beats stay frozen; o_s_tready follows i_m_tready while the last stage holds a beat, else stays high.
// - with stream enable low, inputs ignored except the stream reset.
// - low stream reset clears stream logic at next edge, regardless of enable.
// - stream enable and reset never touch the control port logic; both share the clock i_core_clk.
// - pixel words 24 bits only, three 8-bit components; no 10/12-bit components.
// - beat moves only when ready, valid, enable and reset are all high.
// - beats carry only active picture samples, never blanking or ancillary data.
// - frame start on user bit zero marks exactly the first pixel beat.
// - frame start may rise early while valid stays low.
// - line end marker marks exactly the last pixel beat of a line.
// - without control port, fixed build settings; only reset and enable steer it.
// - control port samples its inputs on the rising edge of its clock.
// - control port uses 32-bit addresses and data, 2-bit responses.
// - control port has its own enable; low enable stalls the port.
// - pipeline latency nine plus one per limit stage, eleven in total.
// - one converted sample per clock cycle sustained.
`timescale 1ns/100ps
`include "vsp_defines.svh"

module vsp_stream_port
    import vsp_pkg::*;
(
    // clock and reset
    input  wire logic                        i_core_clk,
    input  wire logic                        i_nrst,
    // stream enable and synchronous stream reset
    input  wire logic                        i_stream_clk_en,
    input  wire logic                        i_stream_nrst,
    // input stream
    input  wire vsp_pix_t                    i_s_tdata,
    input  wire logic                        i_s_tvalid,
    input  wire logic                        i_s_tuser,
    input  wire logic                        i_s_tlast,
    output logic                             o_s_tready,
    // output stream
    output vsp_pix_t                         o_m_tdata,
    output logic                             o_m_tvalid,
    output logic                             o_m_tuser,
    output logic                             o_m_tlast,
    input  wire logic                        i_m_tready,
    // control port enable and synchronous reset
    input  wire logic                        i_ctl_clk_en,
    input  wire logic                        i_ctl_nrst,
    // control port write channels
    input  wire logic                        i_ctl_awvalid,
    output logic                             o_ctl_awready,
    input  wire logic [`VSP_CTL_ADDR_W-1:0]  i_ctl_awaddr,
    input  wire logic                        i_ctl_wvalid,
    output logic                             o_ctl_wready,
    input  wire logic [`VSP_CTL_DATA_W-1:0]  i_ctl_wdata,
    output vsp_resp_t                        o_ctl_bresp,
    output logic                             o_ctl_bvalid,
    input  wire logic                        i_ctl_bready,
    // control port read channels
    input  wire logic                        i_ctl_arvalid,
    output logic                             o_ctl_arready,
    input  wire logic [`VSP_CTL_ADDR_W-1:0]  i_ctl_araddr,
    output logic                             o_ctl_rvalid,
    input  wire logic                        i_ctl_rready,
    output logic [`VSP_CTL_DATA_W-1:0]       o_ctl_rdata,
    output vsp_resp_t                        o_ctl_rresp
);

    localparam int N = `VSP_LATENCY;

    // ************************************************************
    // stream handshake
    // ************************************************************
    vsp_pix_t data_q  [N];
    logic     valid_q [N];
    logic     sof_q   [N];
    logic     eol_q   [N];
    logic     advance_w;
    logic     step_w;
    logic     in_fire_w;

    // whole pipeline moves when the last stage is empty or taken
    assign advance_w  = !valid_q[N-1] || i_m_tready;
    assign step_w     = i_stream_clk_en && advance_w;
    assign o_s_tready = i_stream_nrst && advance_w;
    assign in_fire_w  = i_s_tvalid && o_s_tready && i_stream_clk_en;

    // ************************************************************
    // pipeline stages, one per latency cycle
    // ************************************************************
    genvar g;
    for (g = 0; g < N; g++) begin : g_stage
        vsp_pix_t prev_data_w;
        logic     prev_valid_w;
        logic     prev_sof_w;
        logic     prev_eol_w;
        if (g == 0) begin : g_head
            assign prev_data_w  = i_s_tdata;
            assign prev_valid_w = in_fire_w;
            assign prev_sof_w   = i_s_tuser;
            assign prev_eol_w   = i_s_tlast;
        end else begin : g_body
            assign prev_data_w  = data_q[g-1];
            assign prev_valid_w = valid_q[g-1];
            assign prev_sof_w   = sof_q[g-1];
            assign prev_eol_w   = eol_q[g-1];
        end
        // stage register: reset first, then enable-gated shift
        always_ff @(posedge i_core_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                data_q[g]  <= '0;
                valid_q[g] <= 1'b0;
                sof_q[g]   <= 1'b0;
                eol_q[g]   <= 1'b0;
            end else if (!i_stream_nrst) begin
                data_q[g]  <= '0;
                valid_q[g] <= 1'b0;
                sof_q[g]   <= 1'b0;
                eol_q[g]   <= 1'b0;
            end else if (step_w) begin
                data_q[g]  <= prev_data_w;
                valid_q[g] <= prev_valid_w;
                sof_q[g]   <= prev_valid_w && prev_sof_w;
                eol_q[g]   <= prev_valid_w && prev_eol_w;
            end
        end
    end

    // output beat straight from the last stage
    assign o_m_tdata  = data_q[N-1];
    assign o_m_tvalid = valid_q[N-1];
    assign o_m_tuser  = sof_q[N-1];
    assign o_m_tlast  = eol_q[N-1];

    // ************************************************************
    // control port: own enable and reset, no registers mapped
    // ************************************************************
    logic bvalid_q;
    logic rvalid_q;
    logic wr_take_w;
    logic rd_take_w;

    // write address and data taken together, one at a time
    assign wr_take_w     = i_ctl_clk_en && !bvalid_q && i_ctl_awvalid && i_ctl_wvalid;
    assign rd_take_w     = i_ctl_clk_en && !rvalid_q && i_ctl_arvalid;
    assign o_ctl_awready = wr_take_w;
    assign o_ctl_wready  = wr_take_w;
    assign o_ctl_arready = rd_take_w;
    assign o_ctl_bvalid  = bvalid_q;
    assign o_ctl_rvalid  = rvalid_q;
    assign o_ctl_bresp   = `VSP_RESP_SLVERR;
    assign o_ctl_rresp   = `VSP_RESP_SLVERR;

    // response flags; stream pins play no part here
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bvalid_q    <= 1'b0;
            rvalid_q    <= 1'b0;
            o_ctl_rdata <= `VSP_RDATA_RST;
        end else if (!i_ctl_nrst) begin
            bvalid_q    <= 1'b0;
            rvalid_q    <= 1'b0;
            o_ctl_rdata <= `VSP_RDATA_RST;
        end else if (i_ctl_clk_en) begin
            bvalid_q    <= wr_take_w || (bvalid_q && !i_ctl_bready);
            rvalid_q    <= rd_take_w || (rvalid_q && !i_ctl_rready);
            o_ctl_rdata <= `VSP_RDATA_RST;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    vsp_run_t run_q;
    // consecutive cycles with a free-flowing stream
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            run_q <= '0;
        end else if (!(i_stream_clk_en && i_stream_nrst && i_m_tready)) begin
            run_q <= '0;
        end else if (run_q != 4'hF) begin
            run_q <= run_q + 4'h1;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    a_out_hold_stall:  assert property (o_m_tvalid && !i_m_tready && i_stream_nrst ##1 i_stream_nrst
        |-> o_m_tvalid && $stable(o_m_tdata) && $stable(o_m_tuser) && $stable(o_m_tlast))
        else $error("output beat changed before acceptance");
    a_freeze_no_en:    assert property (!i_stream_clk_en && i_stream_nrst ##1 i_stream_nrst
        |-> $stable(o_m_tvalid) && $stable(o_m_tdata))
        else $error("stream state moved with enable low");
    a_reset_clears:    assert property (!i_stream_nrst |=> !o_m_tvalid && !o_m_tuser && !o_m_tlast)
        else $error("stream reset did not clear output");
    a_no_ready_reset:  assert property (!i_stream_nrst |-> !o_s_tready)
        else $error("input ready during stream reset");
    a_latency_eleven:  assert property (run_q >= 4'hB && $past(in_fire_w, 11) |-> o_m_tvalid)
        else $error("beat not out after eleven cycles");
    a_marker_align:    assert property (run_q >= 4'hB && $past(in_fire_w, 11)
        |-> o_m_tuser == $past(i_s_tuser, 11) && o_m_tlast == $past(i_s_tlast, 11))
        else $error("frame or line marker misaligned");
    a_full_rate:       assert property (i_stream_nrst && i_m_tready |-> o_s_tready)
        else $error("input stalled while sink ready");
    a_ctl_stall:       assert property (!i_ctl_clk_en && i_ctl_nrst ##1 i_ctl_nrst
        |-> $stable(o_ctl_bvalid) && $stable(o_ctl_rvalid))
        else $error("control port moved with its enable low");
    a_ctl_answer:      assert property (i_ctl_clk_en && i_ctl_nrst && o_ctl_awready |=> o_ctl_bvalid)
        else $error("write accepted without response");

    c_frame_start:     cover property (o_m_tvalid && i_m_tready && o_m_tuser);
    c_line_end:        cover property (o_m_tvalid && i_m_tready && o_m_tlast);
    c_sink_stall:      cover property (o_m_tvalid && !i_m_tready ##1 o_m_tvalid && i_m_tready);
    c_enable_pause:    cover property (in_fire_w ##1 !i_stream_clk_en [*4] ##1 i_stream_clk_en);

endmodule

// ---- testbench/vsp_sink_model.sv ----
// downstream sink model: ready patterns for the output stream
`timescale 1ns/100ps
module vsp_sink_model import vsp_pkg::*; (
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    // pattern select and stream
    input  wire logic [1:0] i_mode,
    input  wire logic       i_tvalid,
    output logic            o_tready
);
    logic [2:0] cnt_q;
    // ready moves after the falling edge only
    always @(negedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 3'h0;
            o_tready <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            case (i_mode)
                2'h0: o_tready <= 1'b1;
                2'h1: o_tready <= cnt_q[1];
                default: o_tready <= i_tvalid & !o_tready;
            endcase
        end
    end
endmodule

// ---- testbench/tb_video_stream_port.sv ----
// self-checking bench of the video stream port
`timescale 1ns/100ps
`include "vsp_defines.svh"
module tb_video_stream_port import vsp_pkg::*; ;
    logic clk = 0, nrst = 0, snrst = 0, c_nrst = 0, c_en = 1, en = 1, gate = 0, lo = 0, strict = 1;
    logic s_v = 0, s_u = 0, s_l = 0, aw = 0, w = 0, b = 0, ar = 0, r = 0, hold = 0;
    logic s_rdy, m_v, m_u, m_l, m_rdy, awr, wr, bv, arr, rv;
    logic [1:0] mode = 2'h0;
    logic [31:0] rd;
    logic [26:0] prv;
    logic [25:0] eq[$];
    vsp_pix_t s_d = '0, m_d;
    vsp_resp_t br, rr;
    int failures = 0, samples_checked = 0, cyc = 0, k, i, tq[$];
    // rows {frame start, line end, pixel}: the output beat equals the input beat
    localparam logic [25:0] ROWS [6] = '{{2'h2, 24'h123456}, {2'h0, 24'hFFFFFF}, {2'h1, 24'h000000},
        {2'h0, 24'hA5A5A5}, {2'h0, 24'h5A5A5A}, {2'h1, 24'h0F0F0F}};
    vsp_stream_port uut (.i_core_clk(clk), .i_nrst(nrst), .i_stream_clk_en(en), .i_stream_nrst(snrst),
        .i_s_tdata(s_d), .i_s_tvalid(s_v), .i_s_tuser(s_u), .i_s_tlast(s_l), .o_s_tready(s_rdy),
        .o_m_tdata(m_d), .o_m_tvalid(m_v), .o_m_tuser(m_u), .o_m_tlast(m_l), .i_m_tready(m_rdy),
        .i_ctl_clk_en(c_en), .i_ctl_nrst(c_nrst), .i_ctl_awvalid(aw), .o_ctl_awready(awr),
        .i_ctl_awaddr(32'h00000010), .i_ctl_wvalid(w), .o_ctl_wready(wr), .i_ctl_wdata(32'hFFFFFFFF),
        .o_ctl_bresp(br), .o_ctl_bvalid(bv), .i_ctl_bready(b), .i_ctl_arvalid(ar), .o_ctl_arready(arr),
        .i_ctl_araddr(32'h00000004), .o_ctl_rvalid(rv), .i_ctl_rready(r), .o_ctl_rdata(rd), .o_ctl_rresp(rr));
    vsp_sink_model sink (.i_core_clk(clk), .i_nrst(nrst), .i_mode(mode), .i_tvalid(m_v), .o_tready(m_rdy));
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic results;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic logic sel(input int n);
        return n == 0 ? awr && wr : n == 1 ? bv : n == 2 ? arr : n == 3 ? rv : s_rdy && en;
    endfunction
    // bounded wait for a handshake, sampled at the rising edge
    task automatic wt(input int n);
        k = 0;
        do begin @(posedge clk); k++; end while (!sel(n) && k < 100);
        if (k >= 100) begin chk(0, "handshake timeout"); results; end
    endtask
    // offer one beat and hold it until taken
    task automatic send(input logic [25:0] v);
        @(negedge clk);
        {s_u, s_l, s_d} = v;
        s_v = 1;
        wt(4);
        eq.push_back(v);
        tq.push_back(cyc);
    endtask
    initial forever #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(negedge clk) en <= lo ? 1'b0 : gate ? cyc[2] : 1'b1;
    // output monitor: held beats, order, markers and latency
    always @(posedge clk) begin
        if (hold) chk({m_v, m_u, m_l, m_d} === prv, "output not held");
        prv = {m_v, m_u, m_l, m_d};
        hold = nrst && snrst && (!en || (m_v && !m_rdy));
        if (m_v && m_rdy && en && snrst) begin
            chk(eq.size() > 0 && {m_u, m_l, m_d} === eq[0], "output beat");
            if (strict) chk(cyc - tq[0] == `VSP_LATENCY, "latency");
            if (eq.size() > 0) begin eq.pop_front(); tq.pop_front(); end
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        {nrst, c_nrst} = 2'h3;
        repeat (22) @(negedge clk);
        snrst = 1;
        chk(m_v === 1'b0 && bv === 1'b0 && rv === 1'b0 && br === `VSP_RESP_SLVERR, "reset");
        s_u = 1;
        repeat (3) @(negedge clk);
        // one frame per ready pattern; enable toggles from the second on
        for (int p = 0; p < 3; p++) begin
            mode = p[1:0];
            gate = (p != 0);
            strict = (p == 0);
            for (i = 0; i < 6; i++) send(ROWS[i]);
            @(negedge clk) {s_v, s_u, s_l} = 3'h0;
            repeat (80) @(posedge clk);
            chk(eq.size() == 0, "beats lost");
        end
        // pending write answer survives a stream reset made with enable low
        @(negedge clk) {aw, w} = 2'h3;
        wt(0);
        @(negedge clk) {aw, w} = 2'h0;
        wt(1);
        chk(br === `VSP_RESP_SLVERR, "write resp");
        send(ROWS[0]);
        @(negedge clk) {s_v, lo, snrst} = 3'h2;
        repeat (32) @(posedge clk) chk(s_rdy === 1'b0, "ready in reset");
        chk(m_v === 1'b0 && bv === 1'b1, "stream reset");
        eq.delete();
        tq.delete();
        @(negedge clk) {lo, snrst, b} = 3'h3;
        @(negedge clk) b = 0;
        chk(bv === 1'b0, "write done");
        // read stalled by control enable, then answered
        @(negedge clk) {ar, c_en} = 2'h2;
        repeat (3) @(posedge clk) chk(arr === 1'b0 && rv === 1'b0, "ctl stall");
        @(negedge clk) c_en = 1;
        wt(2);
        @(negedge clk) ar = 0;
        chk(rv === 1'b1 && rd === `VSP_RDATA_RST && rr === `VSP_RESP_SLVERR, "read");
        @(negedge clk) r = 1;
        @(negedge clk) r = 0;
        chk(rv === 1'b0, "read done");
        // pending read cleared by control reset with its enable low; stream untouched
        @(negedge clk) ar = 1;
        wt(2);
        @(negedge clk) {ar, c_en, c_nrst} = 3'h0;
        chk(rv === 1'b1, "read pending");
        @(negedge clk) chk(rv === 1'b0 && s_rdy === 1'b1, "ctl reset");
        {c_en, c_nrst} = 2'h3;
        results;
    end
    initial begin
        #2000000;
        chk(0, "run timeout");
        results;
    end
endmodule
